// File: osp_pkg.sv
// Functional notes
// - gate low: selects are unclocked level inputs
// - gate high: host clock rise captures selects
// - status outputs driven only while enable low
// - fault_n low on actuator or sensor failure
// - fault_n stays low until power cycles
// - 1xN: code plus one, fallback beyond count
// - echo selects on status, bit3 high
// - dual 1x2: with bit1 high, bit0 picks A, bit2 picks B; bit1 low holds
// - route_en low: off or fallback, bit3 low
// - off position blocks every path
// - no off option: always route somewhere
// - no engagement before 20 ms after power
package osp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DEBOUNCE_NS   = 1000;
  localparam int unsigned DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ENGAGE_MS     = 20;
  localparam int unsigned ENGAGE_CYC    = (ENGAGE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 22;

  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h04;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h08;
  localparam logic [7:0] ADDR_POSITION  = 8'h0c;
  localparam logic [7:0] ADDR_CONFIG    = 8'h10;

  localparam int unsigned IRQ_FAULT  = 0;
  localparam int unsigned IRQ_MOVED  = 1;
  localparam int unsigned IRQ_ENGAGE = 2;
  localparam int unsigned IRQ_W      = 3;

  typedef enum logic [1:0] {
    BUILD_1XN  = 2'h0,
    BUILD_2XN  = 2'h1,
    BUILD_DUAL = 2'h2
  } osp_build_t;

  typedef enum logic [1:0] {
    ST_POWERUP = 2'h0,
    ST_ENGAGED = 2'h1
  } osp_state_t;

  typedef struct packed {
    logic route_en;
    logic sel_bit2;
    logic sel_bit1;
    logic sel_bit0;
  } osp_sel_t;

  typedef struct packed {
    logic       off;
    logic [3:0] chan_a;
    logic [1:0] chan_b;
  } osp_pos_t;

  typedef struct packed {
    osp_build_t build;
    logic [3:0] count;
    logic       off_opt;
  } osp_cfg_t;

  typedef struct packed {
    logic       hold;
    osp_pos_t   pos;
    logic [3:0] status;
  } osp_dec_t;

  localparam osp_cfg_t CFG_RST = '{build: BUILD_1XN, count: 4'h8, off_opt: 1'b0};
  localparam osp_pos_t POS_RST = '{off: 1'b0, chan_a: 4'h1, chan_b: 2'h1};
  localparam osp_sel_t SEL_RST = 4'h0;
endpackage

// File: osp_ctrl.sv
`timescale 1ns/10ps
module osp_ctrl #(
  parameter int unsigned ENGAGE_CYCLES = osp_pkg::ENGAGE_CYC
) (
  // clock and power-on reset
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  // host select pins
  input  wire logic              i_host_clk,
  input  wire logic              i_clock_gate_n,
  input  wire osp_pkg::osp_sel_t i_act_sel,
  input  wire osp_pkg::osp_sel_t i_dflt_sel,
  input  wire logic              i_status_oe_n,
  // internal failure detectors
  input  wire logic              i_actuator_bad,
  input  wire logic              i_sensor_fail,
  // status pins
  output logic [3:0]             o_pos_status,
  output logic                   o_pos_status_oe,
  output logic                   o_fault_n,
  // mechanism
  output osp_pkg::osp_pos_t      o_position,
  output osp_pkg::osp_pos_t      o_dflt_position,
  output logic                   o_engaged,
  // register port
  input  wire logic [7:0]        i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [31:0]            o_rdata,
  output logic                   o_irq
);
  import osp_pkg::*;

  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_CYC - 1);
  localparam logic [CNT_W-1:0] ENG_LAST = CNT_W'(ENGAGE_CYCLES - 1);

  function automatic logic [3:0] clamp_n(input logic [3:0] n);
    clamp_n = (n < 4'h3) ? 4'h3 : ((n > 4'h8) ? 4'h8 : n);
  endfunction

  function automatic osp_dec_t decode(input osp_cfg_t c, input osp_sel_t s);
    logic [3:0] n;
    logic [3:0] fb;
    logic [3:0] code;
    logic [3:0] p;
    logic [3:0] ones;
    osp_dec_t   d;
    n    = clamp_n(c.count);
    fb   = 4'h3;
    code = {1'b0, s.sel_bit2, s.sel_bit1, s.sel_bit0} + 4'h1;
    p    = n >> 1;
    ones = 4'h1 + {3'h0, s.sel_bit0} + {3'h0, s.sel_bit1} + {3'h0, s.sel_bit2};
    d.hold   = 1'b0;
    d.pos    = POS_RST;
    // selects are masked off the status pins only while route_en is low
    d.status = s.route_en ? {1'b1, s.sel_bit2, s.sel_bit1, s.sel_bit0} : 4'h0;
    unique case (c.build)
      BUILD_1XN: begin
        if (n == 4'h8) begin
          fb = 4'h8;
        end else if (n >= 4'h6) begin
          fb = 4'h4;
        end
        if (s.route_en) begin
          d.pos.chan_a = (code > n) ? fb : code;
        end else begin
          d.pos.chan_a = fb;
          d.pos.off    = c.off_opt;
        end
      end
      BUILD_2XN: begin
        if (s.route_en) begin
          d.pos.chan_a = (ones > p) ? p : ones;
        end else begin
          d.pos.chan_a = p;
          d.pos.off    = c.off_opt;
        end
        d.pos.chan_b = d.pos.chan_a[1:0];
      end
      BUILD_DUAL: begin
        if (s.route_en && s.sel_bit1) begin
          d.pos.chan_a = {3'h0, s.sel_bit0} + 4'h1;
          d.pos.chan_b = {1'b0, s.sel_bit2} + 2'h1;
        end else if (s.route_en) begin
          d.hold = 1'b1;
        end else begin
          d.pos.off = c.off_opt;
        end
      end
      default: begin
        d.hold = 1'b1;
      end
    endcase
    if (d.pos.off) begin
      // blocked: no path selected at all
      d.pos.chan_a = 4'h0;
      d.pos.chan_b = 2'h0;
    end
    decode = d;
  endfunction

  // select capture
  logic             hclk_r;
  logic             hclk_nxt;
  osp_sel_t         cand_act_r;
  osp_sel_t         cand_act_nxt;
  osp_sel_t         cand_dflt_r;
  osp_sel_t         cand_dflt_nxt;
  logic [CNT_W-1:0] deb_r;
  logic [CNT_W-1:0] deb_nxt;
  osp_sel_t         act_r;
  osp_sel_t         act_nxt;
  osp_sel_t         dflt_r;
  osp_sel_t         dflt_nxt;

  always_comb begin
    hclk_nxt      = i_host_clk;
    cand_act_nxt  = i_act_sel;
    cand_dflt_nxt = i_dflt_sel;
    deb_nxt       = '0;
    act_nxt       = act_r;
    dflt_nxt      = dflt_r;
    if (i_clock_gate_n) begin
      if (i_host_clk && !hclk_r) begin
        act_nxt  = i_act_sel;
        dflt_nxt = i_dflt_sel;
      end
    end else if ((i_act_sel != cand_act_r) || (i_dflt_sel != cand_dflt_r)) begin
      deb_nxt = '0;
    end else if (deb_r != DEB_LAST) begin
      deb_nxt = deb_r + CNT_W'(1);
    end else begin
      // a level is acted on only once it held still long enough
      deb_nxt  = deb_r;
      act_nxt  = cand_act_r;
      dflt_nxt = cand_dflt_r;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      hclk_r      <= 1'b0;
      cand_act_r  <= SEL_RST;
      cand_dflt_r <= SEL_RST;
      deb_r       <= '0;
      act_r       <= SEL_RST;
      dflt_r      <= SEL_RST;
    end else begin
      hclk_r      <= hclk_nxt;
      cand_act_r  <= cand_act_nxt;
      cand_dflt_r <= cand_dflt_nxt;
      deb_r       <= deb_nxt;
      act_r       <= act_nxt;
      dflt_r      <= dflt_nxt;
    end
  end

  // power-on engagement delay
  osp_state_t       state_r;
  osp_state_t       state_nxt;
  logic [CNT_W-1:0] eng_r;
  logic [CNT_W-1:0] eng_nxt;
  logic             eng_ev;

  always_comb begin
    state_nxt = state_r;
    eng_nxt   = eng_r;
    eng_ev    = 1'b0;
    unique case (state_r)
      ST_POWERUP: begin
        if (eng_r == ENG_LAST) begin
          state_nxt = ST_ENGAGED;
          eng_ev    = 1'b1;
        end else begin
          eng_nxt = eng_r + CNT_W'(1);
        end
      end
      ST_ENGAGED: begin
        state_nxt = ST_ENGAGED;
      end
      default: begin
        state_nxt = ST_POWERUP;
        eng_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_r <= ST_POWERUP;
      eng_r   <= '0;
    end else begin
      state_r <= state_nxt;
      eng_r   <= eng_nxt;
    end
  end

  // position, status pins and fault
  osp_cfg_t   cfg_r;
  osp_cfg_t   cfg_nxt;
  osp_pos_t   pos_r;
  osp_pos_t   pos_nxt;
  osp_pos_t   dpos_r;
  osp_pos_t   dpos_nxt;
  logic [3:0] stat_r;
  logic [3:0] stat_nxt;
  logic       fault_r;
  logic       fault_nxt;
  logic       moved_ev;
  logic       fault_ev;
  osp_dec_t   dec_act;
  osp_dec_t   dec_dflt;

  always_comb begin
    dec_act   = decode(cfg_r, act_r);
    dec_dflt  = decode(cfg_r, dflt_r);
    pos_nxt   = pos_r;
    stat_nxt  = stat_r;
    dpos_nxt  = dec_dflt.hold ? dpos_r : dec_dflt.pos;
    // earlier commands wait in act_r and apply at engagement
    if (state_r == ST_ENGAGED) begin
      stat_nxt = dec_act.status;
      if (!dec_act.hold) begin
        pos_nxt = dec_act.pos;
      end
    end
    moved_ev  = (pos_nxt != pos_r);
    // power-on reset is the only way out
    fault_nxt = fault_r | i_actuator_bad | i_sensor_fail;
    fault_ev  = fault_nxt & ~fault_r;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pos_r   <= POS_RST;
      dpos_r  <= POS_RST;
      stat_r  <= 4'h0;
      fault_r <= 1'b0;
    end else begin
      pos_r   <= pos_nxt;
      dpos_r  <= dpos_nxt;
      stat_r  <= stat_nxt;
      fault_r <= fault_nxt;
    end
  end

  // register port and interrupt
  logic [IRQ_W-1:0] irq_st_r;
  logic [IRQ_W-1:0] irq_st_nxt;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_en_nxt;
  logic [IRQ_W-1:0] irq_clr;
  logic [IRQ_W-1:0] irq_set;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;

  always_comb begin
    cfg_nxt    = cfg_r;
    irq_en_nxt = irq_en_r;
    irq_clr    = '0;
    irq_set    = '0;
    irq_set[IRQ_FAULT]  = fault_ev;
    irq_set[IRQ_MOVED]  = moved_ev;
    irq_set[IRQ_ENGAGE] = eng_ev;
    if (i_wr) begin
      unique case (i_addr)
        ADDR_IRQ_CLEAR: irq_clr    = i_wdata[IRQ_W-1:0];
        ADDR_IRQ_EN:    irq_en_nxt = i_wdata[IRQ_W-1:0];
        ADDR_CONFIG:    cfg_nxt    = osp_cfg_t'(i_wdata[6:0]);
        default:        cfg_nxt    = cfg_r;
      endcase
    end
    // a new event beats a clear in the same cycle
    irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;
    rdata_nxt  = '0;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_STATUS:   rdata_nxt = {29'h0, irq_st_r};
        ADDR_IRQ_EN:   rdata_nxt = {29'h0, irq_en_r};
        ADDR_POSITION: rdata_nxt = {16'h0, fault_r, o_engaged, 3'h0, stat_r, pos_r};
        ADDR_CONFIG:   rdata_nxt = {25'h0, cfg_r};
        default:       rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cfg_r    <= CFG_RST;
      irq_st_r <= '0;
      irq_en_r <= '0;
      rdata_r  <= '0;
    end else begin
      cfg_r    <= cfg_nxt;
      irq_st_r <= irq_st_nxt;
      irq_en_r <= irq_en_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign o_pos_status    = stat_r;
  assign o_pos_status_oe = ~i_status_oe_n;
  assign o_fault_n       = ~fault_r;
  assign o_position      = pos_r;
  assign o_dflt_position = dpos_r;
  assign o_engaged       = (state_r == ST_ENGAGED);
  assign o_rdata         = rdata_r;
  assign o_irq           = |(irq_st_r & irq_en_r);
endmodule

// File: osp_ctrl_props.sv
`timescale 1ns/10ps
module osp_ctrl_props #(
  parameter int unsigned ENGAGE_CYCLES = osp_pkg::ENGAGE_CYC
) (
  // clock and reset
  input wire logic              i_clock,
  input wire logic              i_rst,
  // watched ports
  input wire logic              i_clock_gate_n,
  input wire osp_pkg::osp_sel_t i_act_sel,
  input wire logic              i_status_oe_n,
  input wire logic              i_actuator_bad,
  input wire logic              i_sensor_fail,
  input wire logic              i_rd,
  input wire logic [3:0]        o_pos_status,
  input wire logic              o_pos_status_oe,
  input wire logic              o_fault_n,
  input wire osp_pkg::osp_pos_t o_position,
  input wire logic              o_engaged,
  input wire logic [31:0]       o_rdata
);
  import osp_pkg::*;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  // counts edges since reset until engagement
  always_comb cnt_nxt = o_engaged ? cnt_r : cnt_r + 32'h1;
  always_ff @(posedge i_clock) begin
    if (i_rst) cnt_r <= 32'h0;
    else cnt_r <= cnt_nxt;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_oe_follows: assert property (o_pos_status_oe == !i_status_oe_n)
    else $error("status enable does not follow its input");
  a_fault_sets: assert property ((i_actuator_bad || i_sensor_fail) |=> !o_fault_n)
    else $error("fault output not asserted");
  a_fault_sticky: assert property (!o_fault_n |=> !o_fault_n)
    else $error("fault output released");
  a_st3_low: assert property (!o_pos_status[3] |-> o_pos_status == 4'h0)
    else $error("status not cleared with route disabled");
  a_pre_engage: assert property (!o_engaged |-> o_position == POS_RST && o_pos_status == 4'h0)
    else $error("position moved before engagement");
  a_engage_time: assert property ($rose(o_engaged) |->
    (cnt_r + 32'h1 >= ENGAGE_CYCLES) && (cnt_r <= ENGAGE_CYCLES + 1))
    else $error("engagement delay wrong");
  a_off_blocks: assert property (o_position.off |-> o_position.chan_a == 4'h0 && o_position.chan_b == 2'h0)
    else $error("off position still routes");
  a_unclk_debounce: assert property ((!i_clock_gate_n && i_act_sel != $past(i_act_sel))
    |=> ##1 $stable(o_position)[*8])
    else $error("unclocked select acted before debounce");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
  c_fault: cover property ($fell(o_fault_n));
  c_engage: cover property ($rose(o_engaged));
  c_off: cover property (o_position.off);
endmodule

bind osp_ctrl osp_ctrl_props #(.ENGAGE_CYCLES(ENGAGE_CYCLES)) u_props (
  .i_clock(i_clock), .i_rst(i_rst), .i_clock_gate_n(i_clock_gate_n),
  .i_act_sel(i_act_sel), .i_status_oe_n(i_status_oe_n), .i_actuator_bad(i_actuator_bad),
  .i_sensor_fail(i_sensor_fail), .i_rd(i_rd), .o_pos_status(o_pos_status),
  .o_pos_status_oe(o_pos_status_oe), .o_fault_n(o_fault_n), .o_position(o_position),
  .o_engaged(o_engaged), .o_rdata(o_rdata)
);

// File: osp_host.sv
`timescale 1ns/10ps
module osp_host (
  // clock
  input  wire logic         i_clock,
  // select pins toward the block
  output logic              o_host_clk,
  output logic              o_clock_gate_n,
  output osp_pkg::osp_sel_t o_act_sel,
  output osp_pkg::osp_sel_t o_dflt_sel,
  output logic              o_status_oe_n
);
  import osp_pkg::*;
  initial begin
    o_host_clk = 1'b0;
    o_clock_gate_n = 1'b0;
    o_act_sel = SEL_RST;
    o_dflt_sel = SEL_RST;
    o_status_oe_n = 1'b0;
  end
  // latching use: defaults mirror the active selects
  task automatic send(input logic gate_n, input osp_sel_t sel);
    @(posedge i_clock);
    o_clock_gate_n <= gate_n;
    o_act_sel <= sel;
    o_dflt_sel <= sel;
    o_host_clk <= 1'b0;
    repeat (DEBOUNCE_CYC + 1) @(posedge i_clock);
    o_host_clk <= gate_n;
    // pulse kept wide, well past the minimum clock width
    repeat (50) @(posedge i_clock);
    o_host_clk <= 1'b0;
  endtask
  // one driver for the enable pin, called right after a clock edge
  task automatic set_oe_n(input logic v);
    o_status_oe_n <= v;
  endtask
endmodule

// File: optical_switch_position_ctrl_tb_top.sv
`timescale 1ns/10ps
module optical_switch_position_ctrl_tb_top;
  import osp_pkg::*;
  logic i_clock, i_rst, i_actuator_bad, i_sensor_fail, i_wr, i_rd;
  logic host_clk, gate_n, oe_n, pos_oe, fault_n, engaged, irq;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, rdata;
  logic [3:0] status;
  osp_sel_t act, dflt;
  osp_pos_t pos, dpos;
  int n_fail = 0;
  int total_checks = 0;

  osp_host u_host (.i_clock(i_clock), .o_host_clk(host_clk), .o_clock_gate_n(gate_n),
    .o_act_sel(act), .o_dflt_sel(dflt), .o_status_oe_n(oe_n));
  osp_ctrl #(.ENGAGE_CYCLES(400)) dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_host_clk(host_clk),
    .i_clock_gate_n(gate_n), .i_act_sel(act), .i_dflt_sel(dflt), .i_status_oe_n(oe_n),
    .i_actuator_bad(i_actuator_bad), .i_sensor_fail(i_sensor_fail), .o_pos_status(status),
    .o_pos_status_oe(pos_oe), .o_fault_n(fault_n), .o_position(pos), .o_dflt_position(dpos),
    .o_engaged(engaged), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(rdata), .o_irq(irq));

  task automatic finish_test();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic chk_pos(input logic [3:0] ch, input logic [3:0] st);
    #1 chk(32'(pos.chan_a), 32'(ch));
    chk(32'(status), 32'(st));
  endtask

  task automatic t_engage();
    int i;
    u_host.send(1'b1, 4'hb);
    #1 chk(32'(engaged), 32'h0);
    chk(32'(pos), 32'(POS_RST));
    rd(ADDR_CONFIG, 32'h10);
    rd(8'h20, 32'h0);
    for (i = 0; i < 1000 && engaged !== 1'b1; i++) @(posedge i_clock);
    repeat (2) @(posedge i_clock);
    chk_pos(4'h4, 4'hb);
    chk(32'(dpos.chan_a), 32'h4);
    rd(ADDR_POSITION, 32'h4591);
    $display("t_engage done");
  endtask
  task automatic t_1xn();
    int n, c;
    for (n = 4; n <= 8; n += 4) begin
      wr(ADDR_CONFIG, 32'(n * 2));
      for (c = 0; c < 8; c++) begin
        u_host.send(1'b1, {1'b1, 3'(c)});
        chk_pos(c < n ? 4'(c + 1) : 4'h3, {1'b1, 3'(c)});
      end
    end
    $display("t_1xn done");
  endtask
  task automatic t_off();
    u_host.send(1'b1, 4'h5);
    chk_pos(4'h8, 4'h0);
    chk(32'(pos.off), 32'h0);
    wr(ADDR_CONFIG, 32'h11);
    u_host.send(1'b1, 4'h5);
    #1 chk(32'(pos), 32'h40);
    chk(32'(status), 32'h0);
    $display("t_off done");
  endtask
  task automatic t_2xn();
    wr(ADDR_CONFIG, 32'h2c);
    u_host.send(1'b1, 4'hf);
    chk_pos(4'h3, 4'hf);
    u_host.send(1'b1, 4'h9);
    chk_pos(4'h2, 4'h9);
    u_host.send(1'b1, 4'h7);
    chk_pos(4'h3, 4'h0);
    $display("t_2xn done");
  endtask
  task automatic t_dual();
    wr(ADDR_CONFIG, 32'h50);
    u_host.send(1'b0, 4'he);
    chk_pos(4'h1, 4'he);
    chk(32'(pos.chan_b), 32'h2);
    u_host.send(1'b0, 4'h9);
    chk_pos(4'h1, 4'h9);
    chk(32'(pos.chan_b), 32'h2);
    $display("t_dual done");
  endtask
  task automatic t_fault();
    @(posedge i_clock);
    u_host.set_oe_n(1'b1);
    @(posedge i_clock);
    #1 chk(32'(pos_oe), 32'h0);
    chk(32'(irq), 32'h0);
    @(posedge i_clock);
    u_host.set_oe_n(1'b0);
    wr(ADDR_IRQ_EN, 32'h1);
    rd(ADDR_IRQ_EN, 32'h1);
    @(posedge i_clock);
    i_sensor_fail <= 1'b1;
    i_actuator_bad <= 1'b1;
    @(posedge i_clock);
    i_sensor_fail <= 1'b0;
    i_actuator_bad <= 1'b0;
    #1 chk(32'(fault_n), 32'h0);
    chk(32'(pos_oe), 32'h1);
    rd(ADDR_STATUS, 32'h7);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'h7);
    rd(ADDR_STATUS, 32'h0);
    chk(32'(irq), 32'h0);
    chk(32'(fault_n), 32'h0);
    // power cycle is the only way to clear the fault
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    #1 chk(32'(fault_n), 32'h1);
    chk(32'(engaged), 32'h0);
    chk(32'(pos), 32'(POS_RST));
    rd(ADDR_STATUS, 32'h0);
    $display("t_fault done");
  endtask

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    i_rst = 1'b1;
    i_actuator_bad = 1'b0;
    i_sensor_fail = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    repeat (6) @(posedge i_clock);
    i_rst <= 1'b0;
    t_engage();
    t_1xn();
    t_off();
    t_2xn();
    t_dual();
    t_fault();
    finish_test();
  end
  // whole run is near 4000 cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    finish_test();
  end
endmodule
